/* File: rtl/clic_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "clic_regs.svh"

// Functional notes
// - Master and slave, eight inputs each
// - Slave output feeds master input two
// - Route select picks timer or event timer
// - Slave input zero is inverted alarm
// - Trigger mode per level, except 0,2,8
// - Active-low sources inverted before controllers
// - Pending set by edge or level
// - Acknowledge sets service, keeps pending only if req_hit is set
// - Masked level never raises interrupt
// - Interrupt when unmasked pending request outranks all service bits
// - One acknowledge gives two internal pulses
// - First pulse freezes, sets service bit
// - Master broadcasts slave code after pulse one
// - Vector is base plus input code
// - No request at pulse one gives level 7
// - Auto mode clears service after pulse two
// - Trigger bit 0 edge, 1 level
// - Fixed priority, input 0 highest
// - Service bit blocks equal and lower levels
module clic_top
   import clic_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Interrupt sources
   input wire logic timer0_out,
   input wire logic precision_event_timer0,
   input wire logic clock_alarm_request_n,
   input wire logic [15:0] irq_src,
   input wire logic [15:0] irq_src_active_low,
   // Configuration
   input wire logic legacy_route_select,
   input wire logic [7:0] trigger_select_low,
   input wire logic [7:0] trigger_select_high,
   input wire logic [7:0] master_mask,
   input wire logic [7:0] slave_mask,
   input wire logic mask_load,
   input wire logic [4:0] master_vector_base,
   input wire logic [4:0] slave_vector_base,
   input wire logic auto_end_of_service_mode,
   // End of interrupt
   input wire logic eoi_master,
   input wire logic eoi_slave,
   // Processor acknowledge
   input wire logic cpu_ack_req,
   // Outputs
   output logic cpu_interrupt_out,
   output logic vector_valid,
   output logic [7:0] vector_out,
   output logic internal_ack_pulse_n,
   output logic [2:0] cascade_id,
   output logic [7:0] master_request_pending_bits,
   output logic [7:0] slave_request_pending_bits,
   output logic [7:0] master_in_service_bits,
   output logic [7:0] slave_in_service_bits,
   output logic [7:0] master_level_mask_bits,
   output logic [7:0] slave_level_mask_bits
);

   // ==========================================================
   // Input conditioning
   // ==========================================================
   logic [15:0] line_in;
   logic [15:0] trig_level;
   wire [15:0] norm_src = irq_src ^ irq_src_active_low;
   wire route_timer = legacy_route_select ? precision_event_timer0
                                          : timer0_out;
   wire alarm_in = ~clock_alarm_request_n;
   logic slave_int;
   // Two controllers, slave on master input two
   assign line_in = {norm_src[15:9], alarm_in,
                     norm_src[7:3], slave_int, norm_src[1], route_timer};
   assign trig_level = {trigger_select_high, trigger_select_low}
                       & ~(`CLIC_EDGE_ONLY_MASK);

   // ==========================================================
   // Request, service and mask state
   // ==========================================================
   logic [15:0] prev_r;
   logic [15:0] irr_r, irr_nxt;
   logic [15:0] isr_r, isr_nxt;
   logic [15:0] imr_r;
   clic_ack_state_t st_r, st_nxt;
   logic [1:0] gap_r;

   wire [15:0] req_hit = (line_in & ~prev_r & ~trig_level) |
                         (line_in & trig_level);

   function automatic logic [3:0] pick(input logic [7:0] v);
      logic [3:0] r;
      r = 4'h8;
      for (int i = 7; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b0, 3'(i)};
         end
      end
      return r;
   endfunction

   // Mask of strictly higher levels than top service bit
   function automatic logic [7:0] allow(input logic [7:0] s);
      logic [7:0] a;
      logic [3:0] t;
      t = pick(s);
      a = 8'h00;
      for (int i = 0; i < 8; i++) begin
         if (t[3] || i < int'(t[2:0])) begin
            a[i] = 1'b1;
         end
      end
      return a;
   endfunction

   wire [7:0] s_elig = irr_r[15:8] & ~imr_r[15:8] & allow(isr_r[15:8]);
   wire [7:0] m_elig = irr_r[7:0] & ~imr_r[7:0] & allow(isr_r[7:0]);
   assign slave_int = |s_elig;
   wire [3:0] m_pick = pick(m_elig);
   wire [3:0] s_pick = pick(s_elig);

   // ==========================================================
   // Acknowledge sequencer
   // ==========================================================
   logic [3:0] m_frz_r;
   logic [3:0] s_frz_r;
   wire p1_go = (st_r == ACK_P1);
   wire p2_go = (st_r == ACK_P2);
   wire to_slave = (m_frz_r == {1'b0, `CLIC_CASCADE_IN});

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         ACK_IDLE: begin
            if (cpu_ack_req) begin
               st_nxt = ACK_P1;
            end
         end
         ACK_P1: st_nxt = ACK_GAP1;
         ACK_GAP1: begin
            if (gap_r == 2'd0) begin
               st_nxt = ACK_P2;
            end
         end
         ACK_P2: st_nxt = ACK_DONE;
         ACK_DONE: st_nxt = ACK_IDLE;
         default: st_nxt = ACK_IDLE;
      endcase
   end

   // Pending and service updates
   always_comb begin
      irr_nxt = (irr_r | req_hit) & (line_in | ~trig_level);
      isr_nxt = isr_r;
      // End of interrupt first, so a same-cycle set wins
      if (eoi_master) begin
         isr_nxt[7:0] = isr_r[7:0] & ~(8'(1) << pick(isr_r[7:0]));
      end
      if (eoi_slave) begin
         isr_nxt[15:8] = isr_r[15:8] & ~(8'(1) << pick(isr_r[15:8]));
      end
      if (p1_go && !m_pick[3]) begin
         isr_nxt[m_pick[2:0]] = 1'b1;
         irr_nxt[m_pick[2:0]] = req_hit[m_pick[2:0]];
         if (m_pick[2:0] == `CLIC_CASCADE_IN && !s_pick[3]) begin
            isr_nxt[8 + s_pick[2:0]] = 1'b1;
            irr_nxt[8 + s_pick[2:0]] = req_hit[8 + s_pick[2:0]];
         end
      end
      // Auto end clears service at pulse two end
      if (p2_go && auto_end_of_service_mode && !m_frz_r[3]) begin
         isr_nxt[m_frz_r[2:0]] = 1'b0;
         if (to_slave && !s_frz_r[3]) begin
            isr_nxt[8 + s_frz_r[2:0]] = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev_r <= 16'h0000;
         irr_r <= 16'h0000;
         isr_r <= 16'h0000;
         imr_r <= {`CLIC_MASK_RST, `CLIC_MASK_RST};
      end else begin
         prev_r <= line_in;
         irr_r <= irr_nxt;
         isr_r <= isr_nxt;
         if (mask_load) begin
            imr_r <= {slave_mask, master_mask};
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= ACK_IDLE;
         gap_r <= 2'd0;
         m_frz_r <= 4'h8;
         s_frz_r <= 4'h8;
         cascade_id <= 3'd0;
      end else begin
         st_r <= st_nxt;
         gap_r <= p1_go ? 2'(`CLIC_ACK_GAP - 1)
                        : (gap_r != 2'd0 ? gap_r - 2'd1 : 2'd0);
         if (p1_go) begin
            m_frz_r <= m_pick;
            s_frz_r <= s_pick;
         end
         // Slave code broadcast after first pulse
         if (st_r == ACK_GAP1 && m_frz_r == {1'b0, `CLIC_CASCADE_IN}) begin
            cascade_id <= `CLIC_SLAVE_ID;
         end else if (st_r == ACK_IDLE) begin
            cascade_id <= 3'd0;
         end
      end
   end

   // ==========================================================
   // Vector output
   // ==========================================================
   // Vector byte and spurious default
   wire [7:0] vec_sel = m_frz_r[3] ? {master_vector_base,
                                      `CLIC_SPURIOUS_CODE} :
                        (to_slave && cascade_id == `CLIC_SLAVE_ID) ?
                        {slave_vector_base, s_frz_r[3] ?
                         `CLIC_SPURIOUS_CODE : s_frz_r[2:0]} :
                        {master_vector_base, m_frz_r[2:0]};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         vector_out <= 8'h00;
         vector_valid <= 1'b0;
      end else begin
         vector_valid <= p2_go;
         if (p2_go) begin
            vector_out <= vec_sel;
         end
      end
   end

   assign internal_ack_pulse_n = ~(p1_go | p2_go);
   assign cpu_interrupt_out = |m_elig;
   assign master_request_pending_bits = irr_r[7:0];
   assign slave_request_pending_bits = irr_r[15:8];
   assign master_in_service_bits = isr_r[7:0];
   assign slave_in_service_bits = isr_r[15:8];
   assign master_level_mask_bits = imr_r[7:0];
   assign slave_level_mask_bits = imr_r[15:8];

   // ==========================================================
   // Checks
   // ==========================================================
   // Forced-edge lines already high and not pending
   wire [15:0] held_edge = ~irr_r & prev_r & `CLIC_EDGE_ONLY_MASK;
   chk_masked_quiet: assert property (@(posedge clk) disable iff (rst)
      cpu_interrupt_out |-> (|(irr_r[7:0] & ~imr_r[7:0])))
      else $error("masked level drives interrupt");
   chk_int_on_pend: assert property (@(posedge clk) disable iff (rst)
      (|(irr_r[7:0] & ~imr_r[7:0] & allow(isr_r[7:0]))) |->
      cpu_interrupt_out)
      else $error("interrupt missing for pending level");
   chk_two_pulses: assert property (@(posedge clk) disable iff (rst)
      (st_r == ACK_IDLE && cpu_ack_req) |=> !internal_ack_pulse_n
      ##1 internal_ack_pulse_n [*2] ##1 !internal_ack_pulse_n)
      else $error("acknowledge not two pulses");
   chk_isr_on_p1: assert property (@(posedge clk) disable iff (rst)
      (p1_go && !m_pick[3]) |=> isr_r[$past(m_pick[2:0])])
      else $error("service bit not set on first pulse");
   chk_vec_after_p2: assert property (@(posedge clk)
      disable iff (rst) (p2_go && !to_slave && !m_frz_r[3]) |=>
      vector_valid && vector_out == {$past(master_vector_base),
      m_frz_r[2:0]})
      else $error("vector not returned");
   chk_spurious_vec: assert property (@(posedge clk)
      disable iff (rst) (p2_go && m_frz_r[3]) |=>
      vector_out == {$past(master_vector_base), 3'b111})
      else $error("spurious vector wrong");
   chk_edge_forced: assert property (@(posedge clk) disable iff (rst)
      (|held_edge) |=> (irr_r & $past(held_edge)) == 16'h0000)
      else $error("forced edge level in level mode");
   chk_slave_code: assert property (@(posedge clk) disable iff (rst)
      (st_r == ACK_P2 && to_slave) |-> cascade_id == `CLIC_SLAVE_ID)
      else $error("slave code missing");
   cov_master_ack: cover property (@(posedge clk) p2_go && !to_slave);
   cov_slave_ack: cover property (@(posedge clk) p2_go && to_slave);
   cov_spurious: cover property (@(posedge clk) p2_go && m_frz_r[3]);
   cov_auto_clear: cover property (@(posedge clk)
      p2_go && auto_end_of_service_mode);
endmodule
`default_nettype wire

/* File: rtl/clic_regs.svh */
`ifndef CLIC_REGS_SVH
`define CLIC_REGS_SVH
// Cascade input on the master
`define CLIC_CASCADE_IN 3'd2
// Default level when the request vanished before the answer
`define CLIC_SPURIOUS_CODE 3'd7
// Slave identification broadcast on the cascade bus
`define CLIC_SLAVE_ID 3'd2
// Trigger selects that are forced to edge: master 0, master 2, slave 0
`define CLIC_EDGE_ONLY_MASK 16'h0105
// Reset values
`define CLIC_MASK_RST 8'hFF
`define CLIC_BASE_RST 5'h00
// Gap in clock cycles between the two internal acknowledge pulses
`define CLIC_ACK_GAP 2
`endif

/* File: rtl/clic_pkg.sv */
package clic_pkg;
   typedef enum logic [2:0] {
      ACK_IDLE, ACK_P1, ACK_GAP1, ACK_P2, ACK_DONE
   } clic_ack_state_t;
endpackage

/* File: verification/clic_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========
// Processor side of the acknowledge handshake
module clic_cpu_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Bench control
   input wire logic en,
   input wire logic [3:0] lag,
   // Device side
   input wire logic cpu_interrupt_out,
   input wire logic vector_valid,
   output logic cpu_ack_req
);
   int n;
   initial begin
      cpu_ack_req = 1'b0;
      forever begin
         @(posedge clk);
         #1;
         if (!rst && en && cpu_interrupt_out === 1'b1) begin
            repeat (lag) begin
               @(posedge clk);
               #1;
            end
            cpu_ack_req = 1'b1;
            @(posedge clk);
            #1;
            cpu_ack_req = 1'b0;
            n = 0;
            while (vector_valid !== 1'b1 && n < 12) begin
               @(posedge clk);
               #1;
               n++;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: verification/clic_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "clic_regs.svh"
module clic_top_tb;
   import clic_pkg::*;
   logic clk, rst, timer0_out, precision_event_timer0, clock_alarm_request_n;
   logic legacy_route_select, mask_load, auto_end_of_service_mode, en;
   logic eoi_master, eoi_slave, cpu_ack_req, cpu_interrupt_out, vector_valid;
   logic internal_ack_pulse_n;
   logic [15:0] irq_src, irq_src_active_low;
   logic [7:0] trigger_select_low, trigger_select_high;
   logic [7:0] master_mask, slave_mask;
   logic [7:0] vector_out, r;
   logic [7:0] master_request_pending_bits, slave_request_pending_bits;
   logic [7:0] master_in_service_bits, slave_in_service_bits;
   logic [7:0] master_level_mask_bits, slave_level_mask_bits;
   logic [4:0] master_vector_base, slave_vector_base, b;
   logic [15:0] pend_all, serv_all, mask_all;
   localparam logic [15:0] mask_rst = {2{`CLIC_MASK_RST}};
   logic [3:0] lag;
   logic [2:0] cascade_id;
   int err_count, cmp_count, i, l;
   // ==========
   // Device and processor model
   clic_top u_dut (.clk, .rst, .timer0_out, .precision_event_timer0,
      .clock_alarm_request_n, .irq_src, .irq_src_active_low,
      .legacy_route_select, .trigger_select_low, .trigger_select_high,
      .master_mask, .slave_mask, .mask_load, .master_vector_base,
      .slave_vector_base, .auto_end_of_service_mode, .eoi_master,
      .eoi_slave, .cpu_ack_req, .cpu_interrupt_out, .vector_valid,
      .vector_out, .internal_ack_pulse_n, .cascade_id,
      .master_request_pending_bits, .slave_request_pending_bits,
      .master_in_service_bits, .slave_in_service_bits,
      .master_level_mask_bits, .slave_level_mask_bits);
   clic_cpu_model u_cpu (.clk, .rst, .en, .lag, .cpu_interrupt_out,
      .vector_valid, .cpu_ack_req);
   assign pend_all = {slave_request_pending_bits, master_request_pending_bits};
   assign serv_all = {slave_in_service_bits, master_in_service_bits};
   assign mask_all = {slave_level_mask_bits, master_level_mask_bits};
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // ==========
   // Helpers
   function automatic logic [7:0] lfsr(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction
   function automatic logic [7:0] vec(input logic [4:0] b, input int n);
      return {b, n[2:0]};
   endfunction
   function automatic logic [15:0] serv_exp(input int n);
      return (16'h0001 << n) | (n > 7 ? 16'h0004 : 16'h0000);
   endfunction
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h, want %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict;
      if (err_count == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic eoi(input logic sl);
      eoi_master = 1'b1;
      eoi_slave = sl;
      step(1);
      eoi_master = 1'b0;
      eoi_slave = 1'b0;
      step(1);
   endtask
   task automatic ack(input logic [7:0] exp, input logic cas_exp);
      int k, pulses;
      logic cas;
      pulses = 0;
      cas = 1'b0;
      en = 1'b1;
      for (k = 0; k < 30 && vector_valid !== 1'b1; k++) begin
         step(1);
         if (internal_ack_pulse_n === 1'b0) pulses++;
         if (cascade_id === `CLIC_SLAVE_ID) cas = 1'b1;
      end
      en = 1'b0;
      chk(vector_out, exp);
      chk(16'(pulses), 16'h0002);
      chk(cas, cas_exp);
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      err_count++;
      print_verdict();
   end
   // ==========
   // Main sequence
   initial begin
      {timer0_out, precision_event_timer0, legacy_route_select} = 3'h0;
      {mask_load, auto_end_of_service_mode, en, eoi_master, eoi_slave} = 5'h00;
      clock_alarm_request_n = 1'b1;
      irq_src = 16'h0010;
      irq_src_active_low = 16'h0010;
      {trigger_select_low, trigger_select_high} = 16'h0000;
      {master_mask, slave_mask} = 16'h0000;
      master_vector_base = 5'h08;
      slave_vector_base = 5'h0e;
      lag = 4'h0;
      rst = 1'b1;
      step(2);
      rst = 1'b0;
      chk(mask_all, mask_rst);
      irq_src[3] = 1'b1;
      step(3);
      chk(cpu_interrupt_out, 1'b0);
      mask_load = 1'b1;
      step(1);
      mask_load = 1'b0;
      step(1);
      chk(cpu_interrupt_out, 1'b1);
      chk(mask_all, 16'h0000);
      ack(vec(master_vector_base, 3), 1'b0);
      chk(master_in_service_bits, 16'h0008);
      chk(pend_all, 16'h0000);
      irq_src[3] = 1'b0;
      eoi(1'b0);
      irq_src[6] = 1'b1;
      irq_src[1] = 1'b1;
      step(2);
      ack(vec(master_vector_base, 1), 1'b0);
      chk(cpu_interrupt_out, 1'b0);
      eoi(1'b0);
      chk(cpu_interrupt_out, 1'b1);
      ack(vec(master_vector_base, 6), 1'b0);
      irq_src[6] = 1'b0;
      irq_src[1] = 1'b0;
      eoi(1'b0);
      irq_src[4] = 1'b0;
      step(2);
      ack(vec(master_vector_base, 4), 1'b0);
      irq_src[4] = 1'b1;
      eoi(1'b0);
      legacy_route_select = 1'b1;
      precision_event_timer0 = 1'b1;
      step(2);
      ack(vec(master_vector_base, 0), 1'b0);
      eoi(1'b0);
      timer0_out = 1'b1;
      step(3);
      chk(cpu_interrupt_out, 1'b0);
      clock_alarm_request_n = 1'b0;
      step(2);
      ack(vec(slave_vector_base, 0), 1'b1);
      eoi(1'b1);
      trigger_select_low = 8'h20;
      irq_src[5] = 1'b1;
      step(2);
      ack(vec(master_vector_base, 5), 1'b0);
      eoi(1'b0);
      chk(cpu_interrupt_out, 1'b1);
      // Level request withdrawn before the first pulse
      lag = 4'h3;
      en = 1'b1;
      step(1);
      irq_src[5] = 1'b0;
      ack(vec(master_vector_base, 7), 1'b0);
      chk(master_in_service_bits, 16'h0000);
      lag = 4'h0;
      trigger_select_low = 8'h05;
      step(3);
      chk(cpu_interrupt_out, 1'b0);
      auto_end_of_service_mode = 1'b1;
      irq_src[7] = 1'b1;
      step(2);
      ack(vec(master_vector_base, 7), 1'b0);
      chk(master_in_service_bits, 16'h0000);
      irq_src[7] = 1'b0;
      auto_end_of_service_mode = 1'b0;
      r = 8'h1a;
      for (i = 0; i < 12; i++) begin
         r = lfsr(r);
         l = int'(r[3:0]);
         if (l == 0 || l == 2 || l == 8) l = l + 1;
         master_vector_base = r[7:3];
         slave_vector_base = ~r[7:3];
         lag = {2'b00, r[1:0]};
         b = l > 7 ? slave_vector_base : master_vector_base;
         // Active level follows the source polarity
         irq_src[l] = ~irq_src_active_low[l];
         step(2);
         ack(vec(b, l), l > 7);
         chk(pend_all, 16'h0000);
         chk(serv_all, serv_exp(l));
         irq_src[l] = irq_src_active_low[l];
         eoi(l > 7);
      end
      // Reset again in mid-run
      rst = 1'b1;
      step(2);
      rst = 1'b0;
      chk(mask_all, mask_rst);
      chk(serv_all, 16'h0000);
      chk(cpu_interrupt_out, 1'b0);
      chk(vector_valid, 1'b0);
      print_verdict();
   end
endmodule
`default_nettype wire
